/* File: design/pdmm_memory_map.sv */
// memory map and operand address generation for the cpu core
module pdmm_memory_map
    import pdmm_pkg::*;
#(
    parameter int PROG_AW = 15,
    parameter int DATA_AW = 10
) (
    input wire logic clk,
    input wire logic rstn,
    // program fetch side
    input wire logic fetch_advance,
    input wire logic [15:0] fetch_target,
    input wire logic fetch_jump,
    input wire logic irq_take,
    input wire logic [4:0] irq_index,
    output logic [15:0] prog_addr,
    output logic [PROG_AW-1:0] prog_rom_addr,
    input wire logic [7:0] prog_rom_rdata,
    output logic [7:0] imm_data,
    // operand access from the execution unit
    input wire logic op_valid,
    input wire logic [2:0] op_mode,
    input wire logic op_write,
    input wire logic [7:0] op_addr,
    input wire logic [2:0] op_reg_sel,
    input wire logic op_ind_sel,
    input wire logic [7:0] op_wdata,
    output logic [7:0] op_rdata,
    output logic op_error,
    // core register state
    input wire logic [7:0] accumulator_register,
    input wire logic [7:0] b_register,
    input wire logic [7:0] status_in,
    input wire logic [7:0] stack_pointer,
    input wire logic [15:0] data_pointer_16,
    input wire logic carry_in,
    output logic parity_flag,
    output logic bool_accumulator,
    output logic [1:0] bank_select,
    // sfr bus towards peripherals and ports
    output logic sfr_access,
    output logic sfr_write,
    output logic sfr_page_sel,
    output logic sfr_common,
    output logic [7:0] sfr_addr,
    output logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    // external memory via data pointer
    output logic xmem_access,
    output logic [15:0] xmem_addr,
    input wire logic [7:0] xmem_rdata,
    // page register view
    output logic [7:0] read_page_select,
    output logic [7:0] write_page_select,
    output logic [7:0] sfr_page_select
);
    import pdmm_pkg::*;

    logic [7:0] data_ram [0:(1<<DATA_AW)-1];
    logic [15:0] pc_reg, pc_next;
    logic [7:0] data_read_page_select_reg, data_read_page_select_next, data_write_page_select_reg, data_write_page_select_next, sfr_page_select_reg, sfr_page_select_next;
    logic [7:0] rdata_reg, rdata_next;
    logic err_reg, err_next;
    logic [7:0] eff_addr;
    logic is_sfr, is_page_reg;
    logic [DATA_AW-1:0] rd_full, wr_full;

    // parity of a byte, odd ones gives one
    function automatic logic odd_parity(input logic [7:0] v);
        return ^v;
    endfunction

    // page value joined to an 8-bit implied address
    function automatic logic [9:0] page_join(input logic [7:0] pg, input logic [7:0] a);
        return {pg[1:0], a};
    endfunction

    // fixed vector location for an interrupt index
    function automatic logic [15:0] vector_of(input logic [4:0] idx);
        return VECTOR_BASE + (VECTOR_SPACING * {11'h000, idx});
    endfunction

    // program counter: reset vector, interrupt vector, jump, advance
    always_comb begin
        pc_next = pc_reg;
        if (irq_take) begin
            pc_next = vector_of(irq_index);
        end else if (fetch_jump) begin
            pc_next = fetch_target;
        end else if (fetch_advance) begin
            pc_next = pc_reg + 16'h0001;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pc_reg <= RESET_VECTOR;
        end else begin
            pc_reg <= pc_next;
        end
    end

    // program address always full width, rom is read only
    assign prog_addr = pc_reg;
    assign prog_rom_addr = pc_reg[PROG_AW-1:0];
    assign imm_data = prog_rom_rdata;

    // status word fields
    assign bank_select = {status_in[PSW_BANK_HIGH_BIT], status_in[PSW_BANK_LOW_BIT]};
    assign parity_flag = odd_parity(accumulator_register);
    assign bool_accumulator = carry_in;

    // effective 8-bit address per addressing mode
    always_comb begin
        unique case (op_mode)
            PDMM_MODE_REGISTER: eff_addr = {3'h0, bank_select, op_reg_sel};
            PDMM_MODE_INDIRECT: eff_addr = data_ram[{2'h0, 3'h0, bank_select, 2'h0, op_ind_sel}];
            PDMM_MODE_STACK: eff_addr = stack_pointer;
            default: eff_addr = op_addr;
        endcase
    end

    // sfr space only when direct and address in upper half
    assign is_sfr = op_valid && (op_mode == PDMM_MODE_DIRECT) && eff_addr[7];
    assign is_page_reg = is_sfr && (eff_addr == READ_PAGE_OFFSET
        || eff_addr == WRITE_PAGE_OFFSET || eff_addr == SFR_PAGE_OFFSET);

    // address bit 7 in a non-direct mode selects fixed page 3 upper region, else read/write page
    assign rd_full = (op_mode != PDMM_MODE_DIRECT && eff_addr[7]) ? {2'h3, eff_addr}
        : DATA_AW'({data_read_page_select_reg[1:0], eff_addr});
    assign wr_full = (op_mode != PDMM_MODE_DIRECT && eff_addr[7]) ? {2'h3, eff_addr}
        : DATA_AW'(page_join(data_write_page_select_reg, eff_addr));

    // sfr bus: page select, common registers flagged
    assign sfr_access = is_sfr && !is_page_reg;
    assign sfr_write = sfr_access && op_write;
    assign sfr_addr = eff_addr;
    assign sfr_wdata = op_wdata;
    assign sfr_page_sel = (sfr_page_select_reg == SFR_PAGE1);
    assign sfr_common = (eff_addr == ACC_OFFSET) || (eff_addr == B_OFFSET)
        || (eff_addr == PSW_OFFSET) || !(eff_addr[2:0] == 3'h0);
    assign xmem_access = op_valid && op_mode == PDMM_MODE_POINTER;
    assign xmem_addr = data_pointer_16;

    // page registers and read data
    always_comb begin
        data_read_page_select_next = data_read_page_select_reg;
        data_write_page_select_next = data_write_page_select_reg;
        sfr_page_select_next = sfr_page_select_reg;
        rdata_next = rdata_reg;
        err_next = 1'b0;
        if (op_valid) begin
            unique case (op_mode)
                PDMM_MODE_IMMEDIATE: rdata_next = prog_rom_rdata;
                PDMM_MODE_POINTER: rdata_next = xmem_rdata;
                default: begin
                    if (is_page_reg) begin
                        if (op_write) begin
                            if (eff_addr == READ_PAGE_OFFSET) data_read_page_select_next = op_wdata;
                            if (eff_addr == WRITE_PAGE_OFFSET) data_write_page_select_next = op_wdata;
                            if (eff_addr == SFR_PAGE_OFFSET) sfr_page_select_next = op_wdata;
                        end
                        rdata_next = (eff_addr == READ_PAGE_OFFSET) ? data_read_page_select_reg
                            : (eff_addr == WRITE_PAGE_OFFSET) ? data_write_page_select_reg : sfr_page_select_reg;
                    end else if (is_sfr) begin
                        rdata_next = sfr_rdata;
                    end else begin
                        rdata_next = data_ram[rd_full];
                    end
                    // invalid page flagged, result undefined
                    err_next = !is_sfr && !eff_addr[7] && (op_write
                        ? data_write_page_select_reg[2:0] > PAGE_LAST_VALID || data_write_page_select_reg[7:3] != 5'h00
                        : data_read_page_select_reg[2:0] > PAGE_LAST_VALID || data_read_page_select_reg[7:3] != 5'h00);
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            data_read_page_select_reg <= PAGE_RESET;
            data_write_page_select_reg <= PAGE_RESET;
            sfr_page_select_reg <= PAGE_RESET;
            rdata_reg <= 8'h00;
            err_reg <= 1'b0;
        end else begin
            data_read_page_select_reg <= data_read_page_select_next;
            data_write_page_select_reg <= data_write_page_select_next;
            sfr_page_select_reg <= sfr_page_select_next;
            rdata_reg <= rdata_next;
            err_reg <= err_next;
        end
    end

    // data ram write, no reset on storage
    always_ff @(posedge clk) begin
        if (op_valid && op_write && !is_sfr && op_mode != PDMM_MODE_IMMEDIATE
            && op_mode != PDMM_MODE_POINTER) begin
            data_ram[wr_full] <= op_wdata;
        end
    end

    assign op_rdata = rdata_reg;
    assign op_error = err_reg;
    assign read_page_select = data_read_page_select_reg;
    assign write_page_select = data_write_page_select_reg;
    assign sfr_page_select = sfr_page_select_reg;
endmodule

/* File: design/pdmm_pkg.sv */
// constants for the paged data memory map block
package pdmm_pkg;
    localparam logic [15:0] RESET_VECTOR = 16'h0000;
    localparam logic [15:0] VECTOR_BASE = 16'h0003;
    localparam logic [15:0] VECTOR_SPACING = 16'h0008;
    localparam int VECTOR_COUNT = 18;
    localparam int PROG_BYTES = 32768;
    localparam logic [7:0] READ_PAGE_OFFSET = 8'hfc;
    localparam logic [7:0] WRITE_PAGE_OFFSET = 8'hfd;
    localparam logic [7:0] SFR_PAGE_OFFSET = 8'hff;
    localparam logic [7:0] ACC_OFFSET = 8'he0;
    localparam logic [7:0] B_OFFSET = 8'hf0;
    localparam logic [7:0] PSW_OFFSET = 8'hd0;
    localparam logic [7:0] SP_OFFSET = 8'h81;
    localparam logic [7:0] DPL_OFFSET = 8'h82;
    localparam logic [7:0] DPH_OFFSET = 8'h83;
    localparam logic [7:0] PAGE_RESET = 8'h00;
    localparam logic [7:0] SP_RESET = 8'h07;
    localparam logic [2:0] PAGE_LAST_VALID = 3'h6;
    localparam int PSW_CARRY_BIT = 7;
    localparam int PSW_BANK_HIGH_BIT = 4;
    localparam int PSW_BANK_LOW_BIT = 3;
    localparam int PSW_PARITY_BIT = 0;
    localparam logic [7:0] SFR_PAGE0 = 8'h00;
    localparam logic [7:0] SFR_PAGE1 = 8'h01;
    // operand addressing modes
    typedef enum logic [2:0] {
        PDMM_MODE_DIRECT = 3'b000,
        PDMM_MODE_INDIRECT = 3'b001,
        PDMM_MODE_REGISTER = 3'b010,
        PDMM_MODE_IMMEDIATE = 3'b011,
        PDMM_MODE_STACK = 3'b100,
        PDMM_MODE_POINTER = 3'b101
    } pdmm_mode_e;
endpackage

/* File: bench/pdmm_core_model.sv */
// core-side model: program rom and sfr/xmem responders
module pdmm_core_model (
    input wire logic [14:0] prog_rom_addr,
    input wire logic [7:0] sfr_addr,
    input wire logic [15:0] xmem_addr,
    output logic [7:0] prog_rom_rdata,
    output logic [7:0] sfr_rdata,
    output logic [7:0] xmem_rdata
);
    // fixed rom pattern, no write path exists
    assign prog_rom_rdata = prog_rom_addr[7:0] ^ 8'h5a;
    // peripheral and external data answers
    assign sfr_rdata = sfr_addr ^ 8'ha5;
    assign xmem_rdata = xmem_addr[7:0] ^ xmem_addr[15:8];
endmodule

/* File: bench/pdmm_memory_map_sva.sv */
// checker for fetch, page and status relations
module pdmm_memory_map_chk
    import pdmm_pkg::*;
(
    input wire logic clk, rstn, parity_flag, carry_in, bool_accumulator, irq_take,
    input wire logic fetch_jump, fetch_advance, op_valid, op_write, sfr_access,
    input wire logic [7:0] accumulator_register, status_in, imm_data, prog_rom_rdata,
    input wire logic [7:0] op_addr, op_wdata, write_page_select,
    input wire logic [1:0] bank_select,
    input wire logic [2:0] op_mode,
    input wire logic [4:0] irq_index,
    input wire logic [15:0] prog_addr, fetch_target
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    AST_PARITY: assert property (parity_flag == ^accumulator_register)
        else $error("parity flag mismatch");
    AST_CARRY: assert property (bool_accumulator == carry_in)
        else $error("bit accumulator mismatch");
    AST_BANK: assert property (bank_select == status_in[4:3])
        else $error("bank select mismatch");
    AST_IMM: assert property (imm_data == prog_rom_rdata)
        else $error("immediate byte mismatch");
    AST_VECTOR: assert property (irq_take |=>
        prog_addr == VECTOR_BASE + {8'h00, $past(irq_index), 3'h0})
        else $error("vector address wrong");
    AST_JUMP: assert property (fetch_jump && !irq_take |=> prog_addr == $past(fetch_target))
        else $error("jump target wrong");
    AST_ADVANCE: assert property (fetch_advance && !fetch_jump && !irq_take |=>
        prog_addr == $past(prog_addr) + 16'h0001)
        else $error("fetch advance wrong");
    AST_WPAGE: assert property (op_valid && op_write && op_mode == 3'h0 &&
        op_addr == WRITE_PAGE_OFFSET |=> write_page_select == $past(op_wdata))
        else $error("write page not loaded");
    AST_SFR_DIRECT: assert property (op_valid && op_mode != 3'h0 |-> !sfr_access)
        else $error("sfr reached indirectly");
endmodule
bind pdmm_memory_map pdmm_memory_map_chk u_chk (.*);

/* File: bench/paged_data_memory_map_tb.sv */
// self-checking bench for the paged data memory map
module paged_data_memory_map_tb import pdmm_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rstn = 0, fetch_advance = 0, fetch_jump = 0, irq_take = 0, op_valid = 0;
    logic op_write = 0, op_ind_sel = 0, carry_in = 0;
    logic [15:0] fetch_target = 16'h0000, data_pointer_16 = 16'h0000;
    logic [4:0] irq_index = 5'h00;
    logic [2:0] op_mode = 3'h0, op_reg_sel = 3'h0;
    logic [7:0] op_addr = 8'h00, op_wdata = 8'h00, accumulator_register = 8'h00;
    logic [7:0] b_register = 8'h00, status_in = 8'h00, stack_pointer = SP_RESET;
    wire logic [7:0] prog_rom_rdata, sfr_rdata, xmem_rdata, imm_data, op_rdata, sfr_addr;
    wire logic [7:0] read_page_select, write_page_select, sfr_page_select, sfr_wdata;
    wire logic [15:0] prog_addr, xmem_addr;
    wire logic [14:0] prog_rom_addr;
    wire logic [1:0] bank_select;
    wire logic op_error, parity_flag, bool_accumulator, sfr_access, sfr_write;
    wire logic sfr_page_sel, sfr_common, xmem_access;
    int failures = 0, checked = 0, cyc = 0;
    pdmm_memory_map uut (.*);
    pdmm_core_model model (.*);
    // clock and hang guard
    initial begin
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            failures++;
            end_sim();
        end
    end
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    // one operand access, strobe for a single cycle
    task automatic op(input logic [2:0] m, input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        op_valid = 1;
        op_mode = m;
        op_write = w;
        op_addr = a;
        op_wdata = d;
        @(negedge clk);
        op_valid = 0;
    endtask
    task automatic end_sim();
        $display("checks %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (10) @(negedge clk);
        rstn = 1;
        chk("pc", RESET_VECTOR, prog_addr);
        chk("rpg", PAGE_RESET, read_page_select);
        chk("wpg", PAGE_RESET, write_page_select);
        chk("spg", PAGE_RESET, sfr_page_select);
        for (int i = 0; i < 4; i++) begin
            @(negedge clk);
            irq_take = 1;
            irq_index = 5'(i);
            @(negedge clk);
            irq_take = 0;
            chk("vector", 16'(VECTOR_BASE + VECTOR_SPACING * i), prog_addr);
        end
        @(negedge clk);
        fetch_jump = 1;
        fetch_target = 16'h7ffe;
        @(negedge clk);
        fetch_jump = 0;
        fetch_advance = 1;
        repeat (2) @(negedge clk);
        fetch_advance = 0;
        chk("pc", 16'h8000, prog_addr);
        chk("romaddr", 16'h0000, {1'b0, prog_rom_addr});
        chk("imm", 16'h005a, {8'h00, imm_data});
        for (int p = 1; p < 3; p++) begin
            op(PDMM_MODE_DIRECT, 1, WRITE_PAGE_OFFSET, 8'(p));
            op(PDMM_MODE_DIRECT, 1, 8'h10, 8'(8'h30 + p));
        end
        chk("wpg", 16'h0002, {8'h00, write_page_select});
        for (int p = 1; p < 3; p++) begin
            op(PDMM_MODE_DIRECT, 1, READ_PAGE_OFFSET, 8'(p));
            op(PDMM_MODE_DIRECT, 0, 8'h10, 8'h00);
            chk("paged", 16'(8'h30 + p), {8'h00, op_rdata});
        end
        op(PDMM_MODE_DIRECT, 1, READ_PAGE_OFFSET, 8'h00);
        op(PDMM_MODE_DIRECT, 1, WRITE_PAGE_OFFSET, 8'h00);
        status_in = 8'h08;
        op_reg_sel = 3'h3;
        op_ind_sel = 1;
        op(PDMM_MODE_REGISTER, 1, 8'h00, 8'h77);
        op_reg_sel = 3'h1;
        op(PDMM_MODE_REGISTER, 1, 8'h00, 8'h20);
        op(PDMM_MODE_DIRECT, 1, 8'h20, 8'h55);
        chk("bank", 16'h0001, {14'h0000, bank_select});
        op(PDMM_MODE_DIRECT, 0, 8'h0b, 8'h00);
        chk("reg", 16'h0077, {8'h00, op_rdata});
        op(PDMM_MODE_INDIRECT, 0, 8'h00, 8'h00);
        chk("ind", 16'h0055, {8'h00, op_rdata});
        op(PDMM_MODE_DIRECT, 1, SFR_PAGE_OFFSET, SFR_PAGE1);
        chk("spg", 16'h0001, {8'h00, sfr_page_select});
        op(PDMM_MODE_DIRECT, 0, 8'h90, 8'h00);
        chk("sfr", 16'h0035, {8'h00, op_rdata});
        chk("sfrsel", 16'h0001, {15'h0000, sfr_page_sel});
        chk("common", 16'h0000, {15'h0000, sfr_common});
        op(PDMM_MODE_IMMEDIATE, 0, 8'h00, 8'h00);
        chk("immop", 16'h005a, {8'h00, op_rdata});
        data_pointer_16 = 16'h1234;
        op(PDMM_MODE_POINTER, 0, 8'h00, 8'h00);
        chk("xmem", 16'h0026, {8'h00, op_rdata});
        op(PDMM_MODE_STACK, 1, 8'h00, 8'h66);
        op(PDMM_MODE_STACK, 0, 8'h00, 8'h00);
        chk("stack", 16'h0066, {8'h00, op_rdata});
        op(PDMM_MODE_DIRECT, 1, WRITE_PAGE_OFFSET, 8'h07);
        op(PDMM_MODE_DIRECT, 1, 8'h10, 8'h00);
        chk("err", 16'h0001, {15'h0000, op_error});
        op(PDMM_MODE_DIRECT, 1, WRITE_PAGE_OFFSET, 8'h00);
        chk("noerr", 16'h0000, {15'h0000, op_error});
        for (int i = 0; i < 8; i++) begin
            @(negedge clk);
            accumulator_register = 8'(i * 37);
            carry_in = i[0];
        end
        @(posedge clk);
        chk("parity", 16'h0000, {15'h0000, parity_flag});
        chk("carry", 16'h0001, {15'h0000, bool_accumulator});
        end_sim();
    end
endmodule
